// >>> hw/iolr_pkg.sv
// Purpose: shared constants and carrier types for the I/O line signal router
// Assumes: 10 MHz mclk, Avalon-MM slave with 32-bit data and byte addresses
// Notes: every offset, field position, reset value and timing count lives here
package iolr_pkg;

  // clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam int PPS_PERIOD_MS = 1000;
  localparam int PPS_HALF_CYCLES = CLK_HZ / 1000 * PPS_PERIOD_MS / 2;
  localparam int DEBOUNCE_DEFAULT_US = 10;
  localparam int DEBOUNCE_DEFAULT_CYCLES = DEBOUNCE_DEFAULT_US * (CLK_HZ / 1_000_000);
  localparam int TRIG_DELAY_CYCLES = 8;

  // register byte offsets
  localparam logic [7:0] ADDR_LINE_MODE = 8'h00;
  localparam logic [7:0] ADDR_LINE_SOURCE = 8'h04;
  localparam logic [7:0] ADDR_USER_OUTPUT = 8'h08;
  localparam logic [7:0] ADDR_SOFTWARE_SIGNAL = 8'h0C;
  localparam logic [7:0] ADDR_DEBOUNCE_TIME = 8'h10;
  localparam logic [7:0] ADDR_LINE_STATUS = 8'h14;

  // field positions
  localparam int MODE_BIDIR_OUT_BIT = 0;
  localparam int SEL_ISO_LSB = 0;
  localparam int SEL_BIDIR_LSB = 8;
  localparam int SEL_WIDTH = 4;
  localparam int USER_OUT1_BIT = 0;
  localparam int USER_OUT2_BIT = 1;
  localparam int SW_SIG0_BIT = 0;
  localparam int SW_SIG1_BIT = 1;
  localparam int DEBOUNCE_WIDTH = 16;
  localparam int ST_DB_ISO_BIT = 0;
  localparam int ST_DB_BIDIR_BIT = 1;
  localparam int ST_ISO_OUT_BIT = 2;
  localparam int ST_BIDIR_OUT_BIT = 3;
  localparam int ST_PPS_BIT = 4;
  localparam int ST_FRAME_WAIT_BIT = 5;
  localparam int ST_BIDIR_OUT_MODE_BIT = 6;

  // source selection codes
  localparam int NUM_SOURCES = 15;
  localparam logic [3:0] SRC_FRAME_TRIG_WAIT = 4'h0;
  localparam logic [3:0] SRC_FRAME_TRIG_INTERNAL = 4'h1;
  localparam logic [3:0] SRC_EXPOSURE_ACTIVE = 4'h2;
  localparam logic [3:0] SRC_ACQ_TRIG_WAIT = 4'h3;
  localparam logic [3:0] SRC_ACQ_TRIG_INTERNAL = 4'h4;
  localparam logic [3:0] SRC_SENSOR_READOUT = 4'h5;
  localparam logic [3:0] SRC_DEBOUNCED_ISO_IN = 4'h6;
  localparam logic [3:0] SRC_DEBOUNCED_BIDIR = 4'h7;
  localparam logic [3:0] SRC_USER_OUTPUT1 = 4'h8;
  localparam logic [3:0] SRC_USER_OUTPUT2 = 4'h9;
  localparam logic [3:0] SRC_TIMER_ACTIVE = 4'hA;
  localparam logic [3:0] SRC_SOFTWARE_SIGNAL0 = 4'hB;
  localparam logic [3:0] SRC_SOFTWARE_SIGNAL1 = 4'hC;
  localparam logic [3:0] SRC_LOGIC_BLOCK0 = 4'hD;
  localparam logic [3:0] SRC_PULSE_PER_SECOND = 4'hE;

  // reset values
  localparam logic RST_BIDIR_OUT_MODE = 1'b0;
  localparam logic [3:0] RST_SOURCE = SRC_FRAME_TRIG_WAIT;
  localparam logic [1:0] RST_USER_OUTPUT = 2'h0;
  localparam logic [1:0] RST_SOFTWARE_SIGNAL = 2'h0;
  localparam logic [15:0] RST_DEBOUNCE = 16'(DEBOUNCE_DEFAULT_CYCLES);

  typedef struct packed {
    logic exposureActive;
    logic frameValid;
    logic transferActive;
    logic imageOutDone;
    logic triggerAccepted;
    logic timerActive;
    logic logicBlock0;
  } iolr_core_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } iolr_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } iolr_avs_rsp_t;

  typedef struct packed {
    logic isoOut;
    logic bidirOut;
    logic bidirOeN;
  } iolr_pins_t;

endpackage

// >>> hw/iolr_debounce.sv
// Purpose: synchronise one pin and drop pulses shorter than the debounce time
// Assumes: rawIn is asynchronous to mclk
// Notes: a new level is taken once it has held for debounceCycles cycles
module iolr_debounce (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rawIn,
  input wire logic [15:0] debounceCycles,
  output logic level
);
  import iolr_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic stable_q;
  logic stable_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [16:0] cntNext;

  always_comb
  begin
    cntNext = {1'b0, cnt_q} + 17'h00001;
    stable_d = stable_q;
    cnt_d = 16'h0000;
    if (sync2_q != stable_q)
    begin
      if (cntNext >= {1'b0, debounceCycles})
      begin
        stable_d = sync2_q;
      end
      else
      begin
        cnt_d = cntNext[15:0];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      stable_q <= 1'b0;
      cnt_q <= 16'h0000;
    end
    else if (ce)
    begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
      stable_q <= stable_d;
      cnt_q <= cnt_d;
    end
  end

  assign level = stable_q;

endmodule

// >>> hw/iolr_pps.sv
// Purpose: pulse-per-second square wave
// Assumes: HALF_CYCLES is half the period in mclk cycles
// Notes: starts low after reset, first rise after one half period
module iolr_pps #(
  parameter int HALF_CYCLES = iolr_pkg::PPS_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  output logic pps
);
  import iolr_pkg::*;

  localparam logic [31:0] LAST_COUNT = 32'(HALF_CYCLES - 1);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic pps_q;
  logic pps_d;

  always_comb
  begin
    cnt_d = cnt_q + 32'h00000001;
    pps_d = pps_q;
    if (cnt_q >= LAST_COUNT)
    begin
      cnt_d = 32'h00000000;
      pps_d = ~pps_q;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 32'h00000000;
      pps_q <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      pps_q <= pps_d;
    end
  end

  assign pps = pps_q;

endmodule

// >>> hw/iolr_router.sv
// Purpose: route camera timing and control signals onto the external I/O lines
// Assumes: core signals are on mclk; pin inputs are asynchronous
// Notes: registers on Avalon-MM, one wait state on every access
// Function
// - software picks one of fifteen sources for each output-capable line
// - after reset every output line carries the frame-trigger-wait source
// - frame-trigger-wait is low from exposure start until image output
// - internal frame trigger is the accepted trigger after a processing delay
// - exposure-active is high while the sensor exposes, low afterwards
// - acquisition-wait is low during host transfer, high once it completes
// - internal acquisition trigger marks the start of an image transfer
// - sensor-readout source presents frame valid during sensor readout
// - debounced isolated input and bidirectional line are selectable sources
// - two user outputs drive software-chosen static levels
// - timer-active passes the timer-counter signal, usable as strobe
// - two software-signal sources output their software-assigned levels
// - logic-block source outputs the first logic block result
// - pulse-per-second is a 1 Hz square wave at 50 percent duty
// - bidirectional line is input or output; isolated lines fixed direction
// - trigger pulses shorter than the debounce time are discarded
module iolr_router #(
  parameter int PPS_HALF = iolr_pkg::PPS_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire iolr_pkg::iolr_avs_req_t avsReq,
  output iolr_pkg::iolr_avs_rsp_t avsRsp,
  input wire iolr_pkg::iolr_core_t core,
  input wire logic isoInPin,
  input wire logic bidirInPin,
  output iolr_pkg::iolr_pins_t pins
);
  import iolr_pkg::*;

  // configuration registers
  logic bidirOutMode_q;
  logic bidirOutMode_d;
  logic [3:0] selIso_q;
  logic [3:0] selIso_d;
  logic [3:0] selBidir_q;
  logic [3:0] selBidir_d;
  logic [1:0] userOut_q;
  logic [1:0] userOut_d;
  logic [1:0] swSig_q;
  logic [1:0] swSig_d;
  logic [15:0] debounce_q;
  logic [15:0] debounce_d;

  // bus handshake
  logic waitReq_q;
  logic waitReq_d;
  logic [31:0] readData_q;
  logic [31:0] readData_d;
  logic [31:0] regRead;
  logic wrTake;

  // timing source state
  logic waitLow_q;
  logic waitLow_d;
  logic expPrev_q;
  logic expPrev_d;
  logic xferPrev_q;
  logic xferPrev_d;
  logic acqPulse_q;
  logic acqPulse_d;
  logic [TRIG_DELAY_CYCLES-1:0] trigDly_q;
  logic [TRIG_DELAY_CYCLES-1:0] trigDly_d;

  // line sources and outputs
  logic [1:0] rawIn;
  logic [1:0] dbLevel;
  logic ppsLevel;
  logic [NUM_SOURCES-1:0] srcVec;
  logic [3:0] lineSel [2];
  logic [1:0] line_q;
  logic [1:0] line_d;
  logic bidirOeN_q;
  logic bidirOeN_d;

  function automatic logic [31:0] mergeBytes(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // debounce both input-capable lines
  assign rawIn = {bidirInPin, isoInPin};

  for (genvar g = 0; g < 2; g++)
  begin : gDebounce
    iolr_debounce uDebounce (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .rawIn(rawIn[g]),
      .debounceCycles(debounce_q),
      .level(dbLevel[g])
    );
  end

  iolr_pps #(
    .HALF_CYCLES(PPS_HALF)
  ) uPps (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .pps(ppsLevel)
  );

  // register read mux
  always_comb
  begin
    regRead = 32'h00000000;
    case (avsReq.address)
      ADDR_LINE_MODE:
      begin
        regRead[MODE_BIDIR_OUT_BIT] = bidirOutMode_q;
      end
      ADDR_LINE_SOURCE:
      begin
        regRead[SEL_ISO_LSB +: SEL_WIDTH] = selIso_q;
        regRead[SEL_BIDIR_LSB +: SEL_WIDTH] = selBidir_q;
      end
      ADDR_USER_OUTPUT:
      begin
        regRead[USER_OUT1_BIT] = userOut_q[0];
        regRead[USER_OUT2_BIT] = userOut_q[1];
      end
      ADDR_SOFTWARE_SIGNAL:
      begin
        regRead[SW_SIG0_BIT] = swSig_q[0];
        regRead[SW_SIG1_BIT] = swSig_q[1];
      end
      ADDR_DEBOUNCE_TIME:
      begin
        regRead[DEBOUNCE_WIDTH-1:0] = debounce_q;
      end
      ADDR_LINE_STATUS:
      begin
        regRead[ST_DB_ISO_BIT] = dbLevel[0];
        regRead[ST_DB_BIDIR_BIT] = dbLevel[1];
        regRead[ST_ISO_OUT_BIT] = line_q[0];
        regRead[ST_BIDIR_OUT_BIT] = line_q[1];
        regRead[ST_PPS_BIT] = ppsLevel;
        regRead[ST_FRAME_WAIT_BIT] = ~waitLow_q;
        regRead[ST_BIDIR_OUT_MODE_BIT] = ~bidirOeN_q;
      end
      default:
      begin
        regRead = 32'h00000000;
      end
    endcase
  end

  // one wait state: waitrequest drops for a single cycle per request
  always_comb
  begin
    waitReq_d = 1'b1;
    readData_d = readData_q;
    if ((avsReq.read || avsReq.write) && waitReq_q)
    begin
      waitReq_d = 1'b0;
      readData_d = avsReq.read ? regRead : 32'h00000000;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      waitReq_q <= 1'b1;
      readData_q <= 32'h00000000;
    end
    else if (ce)
    begin
      waitReq_q <= waitReq_d;
      readData_q <= readData_d;
    end
  end

  // write takes effect on the edge where the master sees waitrequest low
  assign wrTake = avsReq.write && !waitReq_q;

  always_comb
  begin
    logic [31:0] merged;
    merged = 32'h00000000;
    bidirOutMode_d = bidirOutMode_q;
    selIso_d = selIso_q;
    selBidir_d = selBidir_q;
    userOut_d = userOut_q;
    swSig_d = swSig_q;
    debounce_d = debounce_q;
    if (wrTake)
    begin
      merged = mergeBytes(regRead, avsReq.writedata, avsReq.byteenable);
      case (avsReq.address)
        ADDR_LINE_MODE:
        begin
          bidirOutMode_d = merged[MODE_BIDIR_OUT_BIT];
        end
        ADDR_LINE_SOURCE:
        begin
          selIso_d = merged[SEL_ISO_LSB +: SEL_WIDTH];
          selBidir_d = merged[SEL_BIDIR_LSB +: SEL_WIDTH];
        end
        ADDR_USER_OUTPUT:
        begin
          userOut_d = {merged[USER_OUT2_BIT], merged[USER_OUT1_BIT]};
        end
        ADDR_SOFTWARE_SIGNAL:
        begin
          swSig_d = {merged[SW_SIG1_BIT], merged[SW_SIG0_BIT]};
        end
        ADDR_DEBOUNCE_TIME:
        begin
          debounce_d = merged[DEBOUNCE_WIDTH-1:0];
        end
        default:
        begin
          bidirOutMode_d = bidirOutMode_q;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      bidirOutMode_q <= RST_BIDIR_OUT_MODE;
      selIso_q <= RST_SOURCE;
      selBidir_q <= RST_SOURCE;
      userOut_q <= RST_USER_OUTPUT;
      swSig_q <= RST_SOFTWARE_SIGNAL;
      debounce_q <= RST_DEBOUNCE;
    end
    else if (ce)
    begin
      bidirOutMode_q <= bidirOutMode_d;
      selIso_q <= selIso_d;
      selBidir_q <= selBidir_d;
      userOut_q <= userOut_d;
      swSig_q <= swSig_d;
      debounce_q <= debounce_d;
    end
  end

  // timing sources derived from the camera core
  always_comb
  begin
    expPrev_d = core.exposureActive;
    xferPrev_d = core.transferActive;
    waitLow_d = waitLow_q;
    if (core.imageOutDone)
    begin
      waitLow_d = 1'b0;
    end
    // a new exposure in the same cycle as image done keeps the wait low
    if (core.exposureActive && !expPrev_q)
    begin
      waitLow_d = 1'b1;
    end
    acqPulse_d = core.transferActive && !xferPrev_q;
    trigDly_d = {trigDly_q[TRIG_DELAY_CYCLES-2:0], core.triggerAccepted};
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      waitLow_q <= 1'b0;
      expPrev_q <= 1'b0;
      xferPrev_q <= 1'b0;
      acqPulse_q <= 1'b0;
      trigDly_q <= '0;
    end
    else if (ce)
    begin
      waitLow_q <= waitLow_d;
      expPrev_q <= expPrev_d;
      xferPrev_q <= xferPrev_d;
      acqPulse_q <= acqPulse_d;
      trigDly_q <= trigDly_d;
    end
  end

  // source vector indexed by selection code
  always_comb
  begin
    srcVec = '0;
    srcVec[SRC_FRAME_TRIG_WAIT] = ~waitLow_q;
    srcVec[SRC_FRAME_TRIG_INTERNAL] = trigDly_q[TRIG_DELAY_CYCLES-1];
    srcVec[SRC_EXPOSURE_ACTIVE] = core.exposureActive;
    srcVec[SRC_ACQ_TRIG_WAIT] = ~core.transferActive;
    srcVec[SRC_ACQ_TRIG_INTERNAL] = acqPulse_q;
    srcVec[SRC_SENSOR_READOUT] = core.frameValid;
    srcVec[SRC_DEBOUNCED_ISO_IN] = dbLevel[0];
    srcVec[SRC_DEBOUNCED_BIDIR] = dbLevel[1];
    srcVec[SRC_USER_OUTPUT1] = userOut_q[0];
    srcVec[SRC_USER_OUTPUT2] = userOut_q[1];
    srcVec[SRC_TIMER_ACTIVE] = core.timerActive;
    srcVec[SRC_SOFTWARE_SIGNAL0] = swSig_q[0];
    srcVec[SRC_SOFTWARE_SIGNAL1] = swSig_q[1];
    srcVec[SRC_LOGIC_BLOCK0] = core.logicBlock0;
    srcVec[SRC_PULSE_PER_SECOND] = ppsLevel;
  end

  assign lineSel[0] = selIso_q;
  assign lineSel[1] = selBidir_q;

  // per-line multiplexer, registered so a selection change cannot glitch
  for (genvar l = 0; l < 2; l++)
  begin : gLineMux
    always_comb
    begin
      line_d[l] = 1'b0;
      if (lineSel[l] < 4'(NUM_SOURCES))
      begin
        line_d[l] = srcVec[lineSel[l]];
      end
    end
  end

  // bidirectional line drives only in output mode
  assign bidirOeN_d = ~bidirOutMode_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      line_q <= 2'h0;
      bidirOeN_q <= 1'b1;
    end
    else if (ce)
    begin
      line_q <= line_d;
      bidirOeN_q <= bidirOeN_d;
    end
  end

  assign avsRsp.readdata = readData_q;
  assign avsRsp.waitrequest = waitReq_q;
  assign pins.isoOut = line_q[0];
  assign pins.bidirOut = line_q[1];
  assign pins.bidirOeN = bidirOeN_q;

endmodule

// >>> dv/iolr_router_sva.sv
// Purpose: port-level checks for the I/O line router
// Assumes: ce held high by the bench
// Notes: shadows the isolated-line source and mode fields from bus writes
module iolr_router_sva #(
  parameter int PPS_HALF = 10
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire iolr_pkg::iolr_avs_req_t avsReq,
  input wire iolr_pkg::iolr_avs_rsp_t avsRsp,
  input wire iolr_pkg::iolr_core_t core,
  input wire logic isoInPin,
  input wire logic bidirInPin,
  input wire iolr_pkg::iolr_pins_t pins
);
  import iolr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] isoSel_q, isoSel_d;
  logic mode_q, mode_d;
  logic wrHit;
  assign wrHit = avsReq.write && !avsRsp.waitrequest && avsReq.byteenable[0];
  always_comb
  begin
    isoSel_d = isoSel_q;
    mode_d = mode_q;
    if (wrHit && avsReq.address == ADDR_LINE_SOURCE)
    begin
      isoSel_d = avsReq.writedata[3:0];
    end
    if (wrHit && avsReq.address == ADDR_LINE_MODE)
    begin
      mode_d = avsReq.writedata[MODE_BIDIR_OUT_BIT];
    end
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      isoSel_q <= RST_SOURCE;
      mode_q <= RST_BIDIR_OUT_MODE;
    end
    else
    begin
      isoSel_q <= isoSel_d;
      mode_q <= mode_d;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_expo_start;
    $rose(core.exposureActive) ##0 isoSel_q == SRC_FRAME_TRIG_WAIT;
  endsequence
  a_wait_pulse: assert property (!avsRsp.waitrequest |=> avsRsp.waitrequest)
    else $error("waitrequest low for two cycles");
  a_wait_cause: assert property ($fell(avsRsp.waitrequest)
    |-> $past(avsReq.read || avsReq.write))
    else $error("answer without request");
  a_rd_unmapped: assert property (avsReq.read && !avsRsp.waitrequest
    && avsReq.address == 8'h20 |-> avsRsp.readdata == 32'h0)
    else $error("unmapped read not zero");
  a_code_unused: assert property (isoSel_q == 4'hF |=> !pins.isoOut)
    else $error("code 15 line not low");
  a_exp_route: assert property (isoSel_q == SRC_EXPOSURE_ACTIVE
    |=> pins.isoOut == $past(core.exposureActive))
    else $error("exposure not routed");
  a_fv_route: assert property (isoSel_q == SRC_SENSOR_READOUT
    |=> pins.isoOut == $past(core.frameValid))
    else $error("frame valid not routed");
  a_acq_wait: assert property (isoSel_q == SRC_ACQ_TRIG_WAIT
    |=> pins.isoOut == !$past(core.transferActive))
    else $error("acquisition wait wrong");
  a_timer_route: assert property (isoSel_q == SRC_TIMER_ACTIVE
    |=> pins.isoOut == $past(core.timerActive))
    else $error("timer not routed");
  a_logic_route: assert property (isoSel_q == SRC_LOGIC_BLOCK0
    |=> pins.isoOut == $past(core.logicBlock0))
    else $error("logic block not routed");
  a_ftw_fall: assert property (s_expo_start |-> ##2 !pins.isoOut)
    else $error("frame wait not low after exposure start");
  a_oe_mode: assert property (pins.bidirOeN == !$past(mode_q))
    else $error("bidir enable does not follow mode");
endmodule
bind iolr_router iolr_router_sva #(.PPS_HALF(PPS_HALF)) u_sva (.mclk(mclk), .rst(rst), .ce(ce),
  .avsReq(avsReq), .avsRsp(avsRsp), .core(core), .isoInPin(isoInPin), .bidirInPin(bidirInPin),
  .pins(pins));

// >>> dv/iolr_ext_equip.sv
// Purpose: external equipment on the I/O lines
// Assumes: pull-up on the open-collector wire, isolated input idles low
// Notes: trigger width is chosen by the caller
module iolr_ext_equip (
  input wire logic mclk,
  input wire iolr_pkg::iolr_pins_t pins,
  output logic isoLevel,
  output wire logic bidirLevel
);
  import iolr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  initial isoLevel = 1'b0;
  // wire pulled up unless the device sinks it
  assign bidirLevel = (!pins.bidirOeN && !pins.bidirOut) ? 1'b0 : 1'b1;
  task automatic pulse_iso(input int width);
    @(posedge mclk);
    isoLevel <= 1'b1;
    repeat (width) @(posedge mclk);
    isoLevel <= 1'b0;
  endtask
endmodule

// >>> dv/iolr_router_tb.sv
// Purpose: self-checking bench for the I/O line router
// Assumes: one wait state per bus access, ce tied high
// Notes: short pps half period to keep the run brief
module iolr_router_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import iolr_pkg::*;
  localparam int HALF = 20;
  localparam logic [15:0] SEL_EXP = 16'h35AE;
  logic mclk, rst, ce, isoInPin, bidirInPin;
  iolr_avs_req_t avsReq;
  iolr_avs_rsp_t avsRsp;
  iolr_core_t core;
  iolr_pins_t pins;
  int n_fail, tests_run, cycles;
  logic [31:0] rd;
  iolr_router #(.PPS_HALF(HALF)) u_iolr_router (.mclk(mclk), .rst(rst), .ce(ce), .avsReq(avsReq),
    .avsRsp(avsRsp), .core(core), .isoInPin(isoInPin), .bidirInPin(bidirInPin), .pins(pins));
  iolr_ext_equip u_iolr_ext_equip (.mclk(mclk), .pins(pins), .isoLevel(isoInPin),
    .bidirLevel(bidirInPin));
  always #50 mclk = ~mclk;
  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avsReq <= '{address:a, read:!w, write:w, writedata:d, byteenable:4'hF};
    do
      @(posedge mclk);
    while (avsRsp.waitrequest !== 1'b0);
    rd = avsRsp.readdata;
    avsReq.read <= 1'b0;
    avsReq.write <= 1'b0;
  endtask
  task automatic t_reset();
    logic [7:0] a[6] = '{ADDR_LINE_MODE, ADDR_LINE_SOURCE, ADDR_USER_OUTPUT,
      ADDR_SOFTWARE_SIGNAL, ADDR_DEBOUNCE_TIME, 8'h20};
    logic [31:0] e[6] = '{0, 0, 0, 0, DEBOUNCE_DEFAULT_CYCLES, 0};
    chk(pins.isoOut, 1);
    chk(pins.bidirOut, 1);
    chk(pins.bidirOeN, 1);
    for (int i = 0; i < 6; i++)
    begin
      bus(0, a[i], 0);
      chk(rd, e[i]);
    end
  endtask
  task automatic t_sources();
    bus(1, ADDR_USER_OUTPUT, 1);
    bus(1, ADDR_SOFTWARE_SIGNAL, 2);
    @(posedge mclk);
    core <= '{exposureActive:1, triggerAccepted:1, timerActive:1, frameValid:1, logicBlock0:1,
      default:0};
    // let the pulled-up bidir wire settle through the default debounce time
    tick(DEBOUNCE_DEFAULT_CYCLES);
    for (int s = 0; s < 16; s++)
    begin
      if (s != 14)
      begin
        bus(1, ADDR_LINE_SOURCE, {20'h0, s[3:0], 4'h0, s[3:0]});
        tick(2);
        chk(pins.isoOut, SEL_EXP[s]);
      end
    end
    @(posedge mclk);
    core <= '0;
  endtask
  task automatic t_frame_wait();
    bus(1, ADDR_LINE_SOURCE, 0);
    tick(2);
    chk(pins.isoOut, 0);
    @(posedge mclk);
    core.imageOutDone <= 1'b1;
    @(posedge mclk);
    core.imageOutDone <= 1'b0;
    tick(1);
    chk(pins.isoOut, 1);
    @(posedge mclk);
    core.exposureActive <= 1'b1;
    tick(1);
    chk(pins.isoOut, 1);
    tick(1);
    chk(pins.isoOut, 0);
  endtask
  task automatic t_acq_trig();
    bus(1, ADDR_LINE_SOURCE, SRC_ACQ_TRIG_INTERNAL);
    tick(2);
    @(posedge mclk);
    core.transferActive <= 1'b1;
    for (int k = 1; k < 4; k++)
    begin
      tick(1);
      chk(pins.isoOut, k == 2);
    end
  endtask
  task automatic t_trig_delay();
    bus(1, ADDR_LINE_SOURCE, SRC_FRAME_TRIG_INTERNAL);
    tick(12);
    @(posedge mclk);
    core.triggerAccepted <= 1'b1;
    @(posedge mclk);
    core.triggerAccepted <= 1'b0;
    tick(7);
    chk(pins.isoOut, 0);
    tick(1);
    chk(pins.isoOut, 1);
    tick(1);
    chk(pins.isoOut, 0);
  endtask
  task automatic t_debounce();
    logic seen;
    seen = 1'b0;
    bus(1, ADDR_DEBOUNCE_TIME, 3);
    bus(1, ADDR_LINE_SOURCE, SRC_DEBOUNCED_ISO_IN);
    u_iolr_ext_equip.pulse_iso(2);
    repeat (10)
    begin
      tick(1);
      seen = seen | pins.isoOut;
    end
    chk(seen, 0);
    u_iolr_ext_equip.pulse_iso(8);
    tick(1);
    chk(pins.isoOut, 1);
    tick(10);
    chk(pins.isoOut, 0);
  endtask
  task automatic t_bidir();
    bus(1, ADDR_LINE_SOURCE, {20'h0, SRC_USER_OUTPUT2, 8'h0});
    bus(1, ADDR_USER_OUTPUT, 2);
    bus(1, ADDR_LINE_MODE, 1);
    tick(2);
    chk(pins.bidirOeN, 0);
    chk(bidirInPin, 1);
    bus(1, ADDR_USER_OUTPUT, 0);
    tick(2);
    chk(bidirInPin, 0);
    bus(1, ADDR_LINE_STATUS, 32'h0);
    bus(0, ADDR_LINE_STATUS, 0);
    chk(rd[ST_BIDIR_OUT_MODE_BIT], 1);
    bus(1, ADDR_LINE_MODE, 0);
    tick(2);
    chk(pins.bidirOeN, 1);
    chk(bidirInPin, 1);
  endtask
  task automatic t_pps();
    int hi, lo;
    hi = 0;
    lo = 0;
    bus(1, ADDR_LINE_SOURCE, SRC_PULSE_PER_SECOND);
    tick(2);
    while (pins.isoOut !== 1'b0 && lo < 100)
    begin
      tick(1);
      lo++;
    end
    while (pins.isoOut !== 1'b1 && hi < 100)
    begin
      tick(1);
      hi++;
    end
    hi = 0;
    lo = 0;
    while (pins.isoOut === 1'b1 && hi < 100)
    begin
      tick(1);
      hi++;
    end
    while (pins.isoOut === 1'b0 && lo < 100)
    begin
      tick(1);
      lo++;
    end
    chk(hi, HALF);
    chk(lo, HALF);
  endtask
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    avsReq = '0;
    core = '0;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    tick(2);
    t_reset();
    t_sources();
    t_frame_wait();
    t_acq_trig();
    t_trig_delay();
    t_debounce();
    t_bidir();
    t_pps();
    report_and_stop();
  end
endmodule
